// >>> dual_timer_pkg.sv
package dual_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL     = 8'h88;
  localparam logic [7:0] IDX_MODE     = 8'h89;
  localparam logic [7:0] IDX_LOW0     = 8'h8A;
  localparam logic [7:0] IDX_LOW1     = 8'h8B;
  localparam logic [7:0] IDX_HIGH0    = 8'h8C;
  localparam logic [7:0] IDX_HIGH1    = 8'h8D;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
  localparam int         IDX_W        = 8;
  localparam int         IDX_LSB      = 2;

  // Control register fields
  localparam int CTRL_OVF1 = 7;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_OVF0 = 5;
  localparam int CTRL_RUN0 = 4;

  // Mode register: one nibble per timer
  localparam int MODE_T1_LSB = 4;
  localparam int MODE_T0_LSB = 0;
  localparam int NIBBLE_W    = 4;

  // Interrupt status and mask fields
  localparam int IRQ_OVF0 = 0;
  localparam int IRQ_OVF1 = 1;

  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [1:0] RST_IRQ   = 2'h0;

  localparam int         PRESCALE_W   = 5;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  localparam logic [7:0] BYTE_MAX     = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_PRESCALE,
    MODE_CASCADE,
    MODE_RELOAD,
    MODE_SPLIT
  } timer_mode_e;

  // Layout matches one nibble of the mode register
  typedef struct packed {
    logic        gate;
    logic        count_ext;
    timer_mode_e mode;
  } timer_cfg_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic       carry;
  } count_step_s;

endpackage

// >>> dual_timer_counter.sv
// How it works
// R1: Two 16-bit timer/counters, each a high and low byte, timer or counter.
// R2: Timer function increments the low byte every core clock cycle.
// R3: Counter function samples the count pin each cycle, counts high-then-low.
// R4: Falling-edge recognition spans two samples, so max rate is half the clock.
// R5: Outside source holds each count pin level for at least one cycle.
// R6: Mode bit 7 set makes timer 1 run only while its gate pin is high.
// R7: Mode bit 3 set makes timer 0 run only while its gate pin is high.
// R8: Mode bit 6 selects external pin (set) or clock (clear) for timer 1.
// R9: Mode bit 2 selects external pin (set) or clock (clear) for timer 0.
// R10: Two-bit mode fields at bits 5:4 for timer 1 and 1:0 for timer 0.
// R11: Mode 00: high byte counts, low byte is a 5-bit prescaler.
// R12: Mode 01: high and low bytes cascade into one 16-bit counter.
// R13: Mode 10: low byte counts and reloads from high byte on overflow.
// R14: Mode 11 on timer 1 stops timer 1.
// R15: Mode 11 on timer 0: low byte on timer 0 controls, high on timer 1.
// R16: Overflow sets the flag; vectoring to the service routine clears it.
// R17: Run bits 6 and 4 of the control register turn timers on and off.
// R18: Carry out of the active counter's top bit is the overflow event.
module dual_timer_counter #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  output logic [1:0]             bresp_o,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  input  wire logic [ADDR_W-1:0] araddr_i,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  input  wire logic              count_pin_timer0_i,
  input  wire logic              count_pin_timer1_i,
  input  wire logic              gate_pin_timer0_i,
  input  wire logic              gate_pin_timer1_i,
  input  wire logic              isr_ack_timer0_i,
  input  wire logic              isr_ack_timer1_i,
  output logic                   overflow_flag_timer0_o,
  output logic                   overflow_flag_timer1_o,
  output logic                   irq_o
);

  initial begin
    if (ADDR_W < dual_timer_pkg::IDX_W + dual_timer_pkg::IDX_LSB + 1) begin
      $error("ADDR_W too small for the register map");
    end
    if (DATA_W != 32) begin
      $error("DATA_W must be 32");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic       top_zero;
    idx      = addr[dual_timer_pkg::IDX_W+dual_timer_pkg::IDX_LSB-1:dual_timer_pkg::IDX_LSB];
    top_zero = (addr[ADDR_W-1:dual_timer_pkg::IDX_W+dual_timer_pkg::IDX_LSB] == '0);
    reg_known = top_zero && (idx == dual_timer_pkg::IDX_CTRL  || idx == dual_timer_pkg::IDX_MODE ||
                             idx == dual_timer_pkg::IDX_LOW0  || idx == dual_timer_pkg::IDX_LOW1 ||
                             idx == dual_timer_pkg::IDX_HIGH0 || idx == dual_timer_pkg::IDX_HIGH1 ||
                             idx == dual_timer_pkg::IDX_IRQ_STAT ||
                             idx == dual_timer_pkg::IDX_IRQ_MASK);
  endfunction

  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] addr);
    idx_of = addr[dual_timer_pkg::IDX_W+dual_timer_pkg::IDX_LSB-1:dual_timer_pkg::IDX_LSB];
  endfunction

  // One counting step of a timer in the given mode
  function automatic dual_timer_pkg::count_step_s step(
    input dual_timer_pkg::timer_mode_e mode,
    input logic [7:0]                  high,
    input logic [7:0]                  low,
    input logic                        inc
  );
    logic [4:0] pre;
    step = '{high: high, low: low, carry: 1'b0};
    pre  = low[dual_timer_pkg::PRESCALE_W-1:0];
    if (inc) begin
      unique case (mode)
        dual_timer_pkg::MODE_PRESCALE: begin
          step.low = {low[7:dual_timer_pkg::PRESCALE_W], 5'(pre + 5'h1)}; // R11
          if (pre == dual_timer_pkg::PRESCALE_MAX) begin
            {step.carry, step.high} = 9'({1'b0, high} + 9'h1); // R18
          end
        end
        dual_timer_pkg::MODE_CASCADE: begin
          {step.carry, step.high, step.low} = 17'({1'b0, high, low} + 17'h1); // R12 R18
        end
        dual_timer_pkg::MODE_RELOAD: begin
          if (low == dual_timer_pkg::BYTE_MAX) begin
            step.low   = high; // R13
            step.carry = 1'b1; // R18
          end else begin
            step.low = 8'(low + 8'h1);
          end
        end
        dual_timer_pkg::MODE_SPLIT: begin
          {step.carry, step.low} = 9'({1'b0, low} + 9'h1); // R15 R18
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wbyte_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              do_write;
  logic [7:0]        wr_idx;

  assign awready_o = !aw_held_ff && !bvalid_ff;
  assign wready_o  = !w_held_ff && !bvalid_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  // Only the low byte lane holds data; other lanes are ignored
  assign do_write  = aw_held_ff && w_held_ff && wlane_ff && reg_known(awaddr_ff) && !bvalid_ff;
  assign wr_idx    = idx_of(awaddr_ff);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wbyte_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= dual_timer_pkg::RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held_ff <= 1'b1;
        wbyte_ff  <= wdata_i[7:0];
        wlane_ff  <= wstrb_i[0];
      end
      if (aw_held_ff && w_held_ff && !bvalid_ff) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= reg_known(awaddr_ff) ? dual_timer_pkg::RESP_OKAY
                                           : dual_timer_pkg::RESP_SLVERR;
      end else if (bvalid_ff && bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and control

  logic [7:0]                 mode_cfg_ff;
  logic                       run0_ff;
  logic                       run1_ff;
  logic                       ovf0_ff;
  logic                       ovf1_ff;
  dual_timer_pkg::timer_cfg_s cfg0;
  dual_timer_pkg::timer_cfg_s cfg1;

  // R10
  assign cfg0 = dual_timer_pkg::timer_cfg_s'(mode_cfg_ff[dual_timer_pkg::MODE_T0_LSB +:
                                                         dual_timer_pkg::NIBBLE_W]);
  assign cfg1 = dual_timer_pkg::timer_cfg_s'(mode_cfg_ff[dual_timer_pkg::MODE_T1_LSB +:
                                                         dual_timer_pkg::NIBBLE_W]);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_cfg_ff <= dual_timer_pkg::RST_MODE;
    end else if (do_write && wr_idx == dual_timer_pkg::IDX_MODE) begin
      mode_cfg_ff <= wbyte_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run0_ff <= dual_timer_pkg::RST_CTRL[dual_timer_pkg::CTRL_RUN0];
      run1_ff <= dual_timer_pkg::RST_CTRL[dual_timer_pkg::CTRL_RUN1];
    end else if (do_write && wr_idx == dual_timer_pkg::IDX_CTRL) begin
      run0_ff <= wbyte_ff[dual_timer_pkg::CTRL_RUN0]; // R17
      run1_ff <= wbyte_ff[dual_timer_pkg::CTRL_RUN1]; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count pin sampling

  logic [1:0] pin_prev_ff;
  logic       fall0;
  logic       fall1;

  // Previous sample high and current sample low: one edge per two samples
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_ff <= 2'h0;
    end else begin
      pin_prev_ff <= {count_pin_timer1_i, count_pin_timer0_i}; // R3
    end
  end

  assign fall0 = pin_prev_ff[0] && !count_pin_timer0_i; // R3 R4 R5
  assign fall1 = pin_prev_ff[1] && !count_pin_timer1_i; // R3 R4 R5

  ////////////////////////////////////////////////////////////////////////////
  // Counting

  logic [7:0]                  low0_ff;
  logic [7:0]                  high0_ff;
  logic [7:0]                  low1_ff;
  logic [7:0]                  high1_ff;
  logic                        en0;
  logic                        en1;
  logic                        inc0;
  logic                        inc1;
  logic                        split0;
  dual_timer_pkg::count_step_s nxt_t0;
  dual_timer_pkg::count_step_s nxt_t1;
  logic [8:0]                  nxt_split_high;
  logic                        ovf_evt0;
  logic                        ovf_evt1;

  assign split0 = (cfg0.mode == dual_timer_pkg::MODE_SPLIT);
  assign en0    = run0_ff && (!cfg0.gate || gate_pin_timer0_i); // R7 R17
  assign en1    = run1_ff && (!cfg1.gate || gate_pin_timer1_i); // R6 R17
  assign inc0   = en0 && (cfg0.count_ext ? fall0 : 1'b1);       // R2 R9
  assign inc1   = en1 && (cfg1.count_ext ? fall1 : 1'b1) &&     // R2 R8
                  (cfg1.mode != dual_timer_pkg::MODE_SPLIT);    // R14

  assign nxt_t0 = step(cfg0.mode, high0_ff, low0_ff, inc0); // R1
  assign nxt_t1 = step(cfg1.mode, high1_ff, low1_ff, inc1); // R1

  // Split high byte is a plain timer gated by timer 1's run bit only
  assign nxt_split_high = 9'({1'b0, high0_ff} + {8'h00, run1_ff}); // R15

  assign ovf_evt0 = nxt_t0.carry;                                   // R18
  // In split mode timer 1 keeps running but its flag belongs to the split byte
  assign ovf_evt1 = split0 ? (run1_ff && nxt_split_high[8]) : nxt_t1.carry; // R15 R18

  // A bus write to a count byte takes priority over the count in that cycle
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low0_ff  <= dual_timer_pkg::RST_COUNT;
      high0_ff <= dual_timer_pkg::RST_COUNT;
    end else begin
      low0_ff  <= (do_write && wr_idx == dual_timer_pkg::IDX_LOW0) ? wbyte_ff : nxt_t0.low;
      if (do_write && wr_idx == dual_timer_pkg::IDX_HIGH0) begin
        high0_ff <= wbyte_ff;
      end else if (split0) begin
        high0_ff <= nxt_split_high[7:0]; // R15
      end else begin
        high0_ff <= nxt_t0.high;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low1_ff  <= dual_timer_pkg::RST_COUNT;
      high1_ff <= dual_timer_pkg::RST_COUNT;
    end else begin
      low1_ff  <= (do_write && wr_idx == dual_timer_pkg::IDX_LOW1)  ? wbyte_ff : nxt_t1.low;
      high1_ff <= (do_write && wr_idx == dual_timer_pkg::IDX_HIGH1) ? wbyte_ff : nxt_t1.high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flags and interrupt

  logic       ctrl_wr;
  logic       stat_wr;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] stat_clr;

  assign ctrl_wr  = do_write && wr_idx == dual_timer_pkg::IDX_CTRL;
  assign stat_wr  = do_write && wr_idx == dual_timer_pkg::IDX_IRQ_STAT;
  assign stat_clr = stat_wr ? wbyte_ff[1:0] : 2'h0;

  // Overflow wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ovf0_ff <= dual_timer_pkg::RST_CTRL[dual_timer_pkg::CTRL_OVF0];
      ovf1_ff <= dual_timer_pkg::RST_CTRL[dual_timer_pkg::CTRL_OVF1];
    end else begin
      if (ovf_evt0) begin
        ovf0_ff <= 1'b1; // R16
      end else if (isr_ack_timer0_i) begin
        ovf0_ff <= 1'b0; // R16
      end else if (ctrl_wr) begin
        ovf0_ff <= wbyte_ff[dual_timer_pkg::CTRL_OVF0];
      end
      if (ovf_evt1) begin
        ovf1_ff <= 1'b1; // R16
      end else if (isr_ack_timer1_i) begin
        ovf1_ff <= 1'b0; // R16
      end else if (ctrl_wr) begin
        ovf1_ff <= wbyte_ff[dual_timer_pkg::CTRL_OVF1];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= dual_timer_pkg::RST_IRQ;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | {ovf_evt1, ovf_evt0};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= dual_timer_pkg::RST_IRQ;
    end else if (do_write && wr_idx == dual_timer_pkg::IDX_IRQ_MASK) begin
      irq_mask_ff <= wbyte_ff[1:0];
    end
  end

  assign irq_o                  = |(irq_stat_ff & irq_mask_ff);
  assign overflow_flag_timer0_o = ovf0_ff;
  assign overflow_flag_timer1_o = ovf1_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic              rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        rd_byte;
  logic [7:0]        rd_idx;
  logic [7:0]        ctrl_view;

  assign arready_o = !rvalid_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;
  assign rd_idx    = idx_of(araddr_i);

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[dual_timer_pkg::CTRL_OVF1] = ovf1_ff;
    ctrl_view[dual_timer_pkg::CTRL_RUN1] = run1_ff;
    ctrl_view[dual_timer_pkg::CTRL_OVF0] = ovf0_ff;
    ctrl_view[dual_timer_pkg::CTRL_RUN0] = run0_ff;
    rd_byte = 8'h00;
    if (reg_known(araddr_i)) begin
      unique case (rd_idx)
        dual_timer_pkg::IDX_CTRL:     rd_byte = ctrl_view;
        dual_timer_pkg::IDX_MODE:     rd_byte = mode_cfg_ff;
        dual_timer_pkg::IDX_LOW0:     rd_byte = low0_ff;
        dual_timer_pkg::IDX_LOW1:     rd_byte = low1_ff;
        dual_timer_pkg::IDX_HIGH0:    rd_byte = high0_ff;
        dual_timer_pkg::IDX_HIGH1:    rd_byte = high1_ff;
        dual_timer_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_ff};
        dual_timer_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_ff};
        default:                      rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= dual_timer_pkg::RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {{(DATA_W-8){1'b0}}, rd_byte};
      rresp_ff  <= reg_known(araddr_i) ? dual_timer_pkg::RESP_OKAY
                                       : dual_timer_pkg::RESP_SLVERR;
    end else if (rvalid_ff && rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// >>> dual_timer_asserts.sv
module dual_timer_asserts (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  rresp_o,
  input wire logic        isr_ack_timer0_i,
  input wire logic        overflow_flag_timer0_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_rd_taken;
    arvalid_i && arready_o;
  endsequence
  sequence s_rd_stall;
    rvalid_o && !rready_i;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  property p_write_ans;
    s_wr_taken |-> ##2 bvalid_o;
  endproperty
  a_write_ans: assert property (p_write_ans) else $error("write response late");
  property p_read_ans;
    s_rd_taken |=> rvalid_o;
  endproperty
  a_read_ans: assert property (p_read_ans) else $error("read data late");
  property p_rvalid_hold;
    s_rd_stall |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data moved while stalled");
  property p_b_drop;
    bvalid_o && bready_i |=> !bvalid_o;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response not retired");
  property p_aw_refuse;
    bvalid_o |-> !awready_o && !wready_o;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while answering");
  property p_ar_refuse;
    rvalid_o |-> !arready_o;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answering");
  property p_rdata_hi;
    rvalid_o |-> rdata_o[31:8] == 24'h00_0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits not zero");
  // Only a vector acknowledge or a software write may drop the flag
  property p_flag0_fall;
    $fell(overflow_flag_timer0_o) |-> $past(isr_ack_timer0_i) || $rose(bvalid_o);
  endproperty
  a_flag0_fall: assert property (p_flag0_fall) else $error("flag dropped unasked");
  property p_irq_fall;
    $fell(irq_o) |-> $rose(bvalid_o);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unasked");
endmodule

bind dual_timer_counter dual_timer_asserts u_chk (
  .core_clk_i, .nrst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o,
  .bready_i, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .rdata_o, .rresp_o,
  .isr_ack_timer0_i, .overflow_flag_timer0_o, .irq_o
);

// >>> pin_source.sv
module pin_source (
  input  wire logic clk_i,
  output logic      pin0_o,
  output logic      pin1_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Count pins idle high, as with a pull-up
  initial begin
    pin0_o = 1'b1;
    pin1_o = 1'b1;
  end

  // Trailing idle lets the last edge settle before anyone reads the count
  task automatic pulses(input int sel, input int n, input int hi, input int lo);
    for (int k = 0; k < n; k++) begin
      if (sel == 0) pin0_o <= 1'b0;
      else pin1_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      if (sel == 0) pin0_o <= 1'b1;
      else pin1_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        is_rd;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } note_s;

  logic        core_clk_i, nrst_i, awvalid_i, awready_o, wvalid_i, wready_o;
  logic        bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
  logic [11:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  wstrb_i;
  logic [1:0]  bresp_o, rresp_o;
  logic        count_pin_timer0_i, count_pin_timer1_i, gate_pin_timer0_i, gate_pin_timer1_i;
  logic        isr_ack_timer0_i, isr_ack_timer1_i, irq_o;
  logic        overflow_flag_timer0_o, overflow_flag_timer1_o;
  logic [15:0] lfsr_q;
  note_s       notes[$];
  note_s       nt;
  int          errors, tests_run, cyc, n, hi, lo;

  dual_timer_counter dut (
    .core_clk_i, .nrst_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o, .wdata_i,
    .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .rvalid_o,
    .rready_i, .rdata_o, .rresp_o, .count_pin_timer0_i, .count_pin_timer1_i,
    .gate_pin_timer0_i, .gate_pin_timer1_i, .isr_ack_timer0_i, .isr_ack_timer1_i,
    .overflow_flag_timer0_o, .overflow_flag_timer1_o, .irq_o
  );
  pin_source u_src (.clk_i(core_clk_i), .pin0_o(count_pin_timer0_i), .pin1_o(count_pin_timer1_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] resp = dual_timer_pkg::RESP_OKAY);
    logic aw_done;
    logic w_done;
    notes.push_back('{1'b0, '0, '0, resp});
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr_i <= {2'b00, idx, 2'b00};
    wdata_i <= {24'h00_0000, d};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (!aw_done && awready_o) begin
        aw_done = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w_done && wready_o) begin
        w_done = 1'b1;
        wvalid_i <= 1'b0;
      end
    end while (!bvalid_o);
    bready_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [7:0] mask = 8'hFF,
                    input logic [1:0] resp = dual_timer_pkg::RESP_OKAY);
    notes.push_back('{1'b1, {24'h00_0000, exp}, {24'h00_0000, mask}, resp});
    araddr_i <= {2'b00, idx, 2'b00};
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o);
    rready_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic expect_flag(input int t, input logic v);
    int k;
    k = 0;
    while (((t == 0) ? overflow_flag_timer0_o : overflow_flag_timer1_o) !== v && k < 300) begin
      @(posedge core_clk_i);
      k++;
    end
    check({31'h0000_0000, (t == 0) ? overflow_flag_timer0_o : overflow_flag_timer1_o},
          {31'h0000_0000, v});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  always @(posedge core_clk_i) begin
    if ((bvalid_o && bready_i) || (rvalid_o && rready_i)) begin
      nt = notes.pop_front();
      if (nt.is_rd) check(rdata_o & nt.mask, nt.data);
      check({30'h0000_0000, nt.is_rd ? rresp_o : bresp_o}, {30'h0000_0000, nt.resp});
    end
  end

  initial begin
    {nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {gate_pin_timer0_i, gate_pin_timer1_i, isr_ack_timer0_i, isr_ack_timer1_i} = '0;
    awaddr_i = '0;
    araddr_i = '0;
    wdata_i = '0;
    wstrb_i = 4'hF;
    lfsr_q = 16'h8D76;
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rd(dual_timer_pkg::IDX_CTRL, 8'h00);
    rd(dual_timer_pkg::IDX_MODE, 8'h00);
    wr(8'h00, 8'hFF, dual_timer_pkg::RESP_SLVERR);
    rd(8'h00, 8'h00, 8'hFF, dual_timer_pkg::RESP_SLVERR);
    // Prescaler: 33 edges at the fastest legal rate
    wr(dual_timer_pkg::IDX_MODE, 8'h04);
    wr(dual_timer_pkg::IDX_CTRL, 8'h10);
    u_src.pulses(0, 33, 1, 1);
    rd(dual_timer_pkg::IDX_HIGH0, 8'h01);
    rd(dual_timer_pkg::IDX_LOW0, 8'h01, 8'h1F);
    rd(dual_timer_pkg::IDX_CTRL, 8'h10);
    // Auto-reload
    wr(dual_timer_pkg::IDX_CTRL, 8'h00);
    wr(dual_timer_pkg::IDX_MODE, 8'h06);
    wr(dual_timer_pkg::IDX_HIGH0, 8'hF0);
    wr(dual_timer_pkg::IDX_LOW0, 8'hFE);
    wr(dual_timer_pkg::IDX_CTRL, 8'h10);
    u_src.pulses(0, 2, 1, 2);
    expect_flag(0, 1'b1);
    rd(dual_timer_pkg::IDX_LOW0, 8'hF0);
    u_src.pulses(0, 1, 2, 1);
    rd(dual_timer_pkg::IDX_LOW0, 8'hF1);
    isr_ack_timer0_i <= 1'b1;
    @(posedge core_clk_i);
    isr_ack_timer0_i <= 1'b0;
    @(posedge core_clk_i);
    expect_flag(0, 1'b0);
    // Gated 16-bit counting
    for (int t = 0; t < 2; t++) begin
      lfsr_q = lfsr_next(lfsr_q);
      n = 1 + int'(lfsr_q[2:0]);
      hi = 1 + int'(lfsr_q[4:3]);
      lo = 1 + int'(lfsr_q[6:5]);
      wr(dual_timer_pkg::IDX_CTRL, 8'h00);
      wr(dual_timer_pkg::IDX_MODE, t ? 8'hD0 : 8'h0D);
      wr(t ? dual_timer_pkg::IDX_LOW1 : dual_timer_pkg::IDX_LOW0, 8'h00);
      wr(dual_timer_pkg::IDX_CTRL, t ? 8'h40 : 8'h10);
      u_src.pulses(t, 3, 1, 1);
      if (t == 1) gate_pin_timer1_i <= 1'b1;
      else gate_pin_timer0_i <= 1'b1;
      @(posedge core_clk_i);
      u_src.pulses(t, n, hi, lo);
      gate_pin_timer0_i <= 1'b0;
      gate_pin_timer1_i <= 1'b0;
      rd(t ? dual_timer_pkg::IDX_LOW1 : dual_timer_pkg::IDX_LOW0, 8'(n));
    end
    // 16-bit timer wrap
    wr(dual_timer_pkg::IDX_CTRL, 8'h00);
    wr(dual_timer_pkg::IDX_MODE, 8'h10);
    wr(dual_timer_pkg::IDX_HIGH1, 8'hFF);
    wr(dual_timer_pkg::IDX_LOW1, 8'hFE);
    wr(dual_timer_pkg::IDX_IRQ_MASK, 8'h02);
    wr(dual_timer_pkg::IDX_CTRL, 8'h40);
    expect_flag(1, 1'b1);
    check({31'h0000_0000, irq_o}, 32'h0000_0001);
    wr(dual_timer_pkg::IDX_CTRL, 8'h00);
    wr(dual_timer_pkg::IDX_IRQ_MASK, 8'h00);
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    wr(dual_timer_pkg::IDX_IRQ_MASK, 8'h02);
    check({31'h0000_0000, irq_o}, 32'h0000_0001);
    rd(dual_timer_pkg::IDX_IRQ_STAT, 8'h02, 8'h02);
    wr(dual_timer_pkg::IDX_IRQ_STAT, 8'h02);
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    // Split mode: timer 1 run bit drives the high byte of timer 0
    wr(dual_timer_pkg::IDX_MODE, 8'h73);
    wr(dual_timer_pkg::IDX_HIGH0, 8'hFE);
    wr(dual_timer_pkg::IDX_LOW1, 8'h00);
    wr(dual_timer_pkg::IDX_CTRL, 8'h40);
    expect_flag(1, 1'b1);
    u_src.pulses(1, 3, 1, 1);
    rd(dual_timer_pkg::IDX_LOW1, 8'h00);
    final_report();
  end
endmodule
